//--- logic/twp_pkg.sv
/*
  package for the wave/pulse timer: register map, field layout, modes.
  assumes a classic wishbone slave with 32-bit data, byte offsets.
*/
package twp_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_FUNC   = 8'h00; // timer_function_register
  localparam logic [7:0] ADDR_MOD_LO = 8'h04;
  localparam logic [7:0] ADDR_MOD_HI = 8'h08;
  localparam logic [7:0] ADDR_START  = 8'h0C;
  localparam logic [7:0] ADDR_COUNT  = 8'h10; // read buffer
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_MASK   = 8'h18;

  // timer_function_register fields
  localparam int MODE_LSB = 0;
  localparam int MODE_W   = 3;
  localparam int PRE_LSB  = 3;
  localparam int PRE_W    = 2;
  localparam int POL_BIT  = 5;
  localparam int FUNC_W   = 6;

  localparam logic [MODE_W-1:0] MODE_STOP0  = 3'h0;
  localparam logic [MODE_W-1:0] MODE_SQUARE = 3'h5;
  localparam logic [MODE_W-1:0] MODE_PULSE  = 3'h6;
  localparam logic [MODE_W-1:0] MODE_STOP7  = 3'h7;

  localparam logic [PRE_W-1:0] PRE_DIV1  = 2'h0;
  localparam logic [PRE_W-1:0] PRE_DIV2  = 2'h1;
  localparam logic [PRE_W-1:0] PRE_DIV64 = 2'h2;

  localparam logic [5:0] PRE64_LAST = 6'h3F;
  localparam logic [5:0] PRE64_HALF = 6'h20;
  localparam logic [5:0] PRE_ZERO   = 6'h00;

  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [15:0] CNT_ONE   = 16'h0001;

  // interrupt status bits
  localparam int IRQ_W     = 2;
  localparam int IRQ_TC    = 0; // terminal count reached
  localparam int IRQ_RDBLK = 1; // buffer update suppressed by read

  typedef struct packed {
    logic              pol;
    logic [PRE_W-1:0]  pre;
    logic [MODE_W-1:0] mode;
  } twp_func_t;

  typedef struct packed {
    logic [7:0] adr;
    logic       we;
    logic [3:0] sel;
    logic [31:0] dat;
  } twp_req_t;

  function automatic logic twp_is_stop(input logic [MODE_W-1:0] m);
    return (m == MODE_STOP0) || (m == MODE_STOP7);
  endfunction : twp_is_stop

endpackage : twp_pkg

//--- logic/twp_timer.sv
/*
  wave/pulse timer core with wishbone register slave.
  assumes timer_source_clock is an asynchronous pin, slower than clk_i/4;
  gate pin sampled only for completeness of the pin set.
*/
// Our own choices: the register addresses and the Wishbone register port.
// Overview of operation
// RL1 - square mode output active at start
// RL2 - square: decrement, toggle at zero, reload
// RL3 - square period two times prescale times modulus+1
// RL4 - pulse width half, one, 32 source clocks
// RL5 - pulse: decrement, pulse, reload, repeat forever
// RL6 - host programs stop, mode, modulus, start
// RL7 - stop mode halts, clears prescaler, clock high
// RL8 - buffer updates on count clock falling edge
// RL9 - reads suppress buffer update until next edge
// RL10 - running modulus write waits for reload
// RL11 - stopped modulus write loads when clock high
// RL12 - modulus write leaves prescaler untouched
// RL13 - mode from low three function bits
// RL14 - stop codes: stopped, clock high, output idle
// RL15 - counting begins at start register write
// RL16 - count clock is source divided 1, 2, 64
`timescale 1ns/10ps
module twp_timer
  import twp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // timer pins
  input  wire logic        timer_source_clock_i,
  input  wire logic        timer_gate_input_i,
  output logic             timer_out_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] src_sync_q, src_sync_d;
  logic [1:0] gate_sync_q, gate_sync_d;
  logic       src_prev_q, src_prev_d;
  logic       src_rise, src_fall;

  always_comb begin
    src_sync_d  = {src_sync_q[0], timer_source_clock_i};
    gate_sync_d = {gate_sync_q[0], timer_gate_input_i};
    src_prev_d  = src_sync_q[1];
    src_rise    = src_sync_q[1] & ~src_prev_q;
    src_fall    = ~src_sync_q[1] & src_prev_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_sync_q  <= 2'h0;
      gate_sync_q <= 2'h0;
      src_prev_q  <= 1'b0;
    end else begin
      src_sync_q  <= src_sync_d;
      gate_sync_q <= gate_sync_d;
      src_prev_q  <= src_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  twp_req_t req;
  logic     acc, wr, rd;
  logic     wr_func, wr_lo, wr_hi, wr_start, rd_count, rd_status;

  always_comb begin
    req       = '{adr: adr_i, we: we_i, sel: sel_i, dat: dat_i};
    acc       = cyc_i & stb_i & ~ack_o;
    wr        = acc & req.we & req.sel[0];
    rd        = acc & ~req.we;
    wr_func   = wr & (req.adr == ADDR_FUNC);
    wr_lo     = wr & (req.adr == ADDR_MOD_LO);
    wr_hi     = wr & (req.adr == ADDR_MOD_HI);
    wr_start  = wr & (req.adr == ADDR_START);
    rd_count  = rd & (req.adr == ADDR_COUNT);
    rd_status = rd & (req.adr == ADDR_STATUS);
  end

  ////////////////////////////////////////////////////////////////////////
  // timer state

  typedef enum logic [1:0] {ST_STOP, ST_ARMED, ST_RUN} twp_state_t;

  twp_state_t       st_q, st_d;
  twp_func_t        func_q, func_d;
  logic [15:0]      mod_q, mod_d;
  logic [15:0]      cnt_q, cnt_d;
  logic [15:0]      buf_q, buf_d;
  logic [5:0]       pre_q, pre_d;
  logic             iclk_q, iclk_d;
  logic             out_q, out_d;
  logic             pend_q, pend_d;
  logic [IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic [31:0]      dat_q, dat_d;
  logic             ack_q, ack_d;
  logic             tick, ifall, irise, tc, pre_wrap;
  logic             pulse_end;

  always_comb begin
    st_d   = st_q;
    func_d = func_q;
    mod_d  = mod_q;
    cnt_d  = cnt_q;
    buf_d  = buf_q;
    pre_d  = pre_q;
    iclk_d = iclk_q;
    out_d  = out_q;
    pend_d = pend_q;
    stat_d = stat_q;
    mask_d = mask_q;
    tick   = 1'b0;
    ifall  = 1'b0;
    irise  = 1'b0;
    tc     = 1'b0;
    pre_wrap  = 1'b0;
    pulse_end = 1'b0;

    // prescaler and internal_count_clock
    if (st_q == ST_RUN) begin
      unique case (func_q.pre)
        PRE_DIV1: begin
          if (src_fall) ifall = 1'b1;                      // RL16
          if (src_rise) irise = 1'b1;
        end
        PRE_DIV2: begin
          if (src_rise) begin
            pre_d[0] = ~pre_q[0];                          // RL16
            if (pre_q[0]) irise = 1'b1;
            else ifall = 1'b1;
          end
        end
        default: begin
          if (src_rise) begin
            pre_d    = pre_q + 6'h01;                      // RL16
            pre_wrap = (pre_q == PRE64_LAST);
            if (pre_q == PRE_ZERO) ifall = 1'b1;
            if (pre_q == PRE64_HALF) irise = 1'b1;
          end
        end
      endcase
      if (ifall) iclk_d = 1'b0;
      if (irise) iclk_d = 1'b1;
      tick = ifall;
    end

    // counting, reload and output
    if (tick) begin
      if (cnt_q == CNT_ZERO) begin
        tc    = 1'b1;
        cnt_d = mod_q;                                     // RL10 RL2 RL5
        if (func_q.mode == MODE_SQUARE) out_d = ~out_q;    // RL2 RL3
        if (func_q.mode == MODE_PULSE) out_d = 1'b1;       // RL4
      end else begin
        cnt_d = cnt_q - CNT_ONE;                           // RL2 RL5
      end
      if (rd_count) begin
        pend_d = 1'b1;                                     // RL9
      end else begin
        buf_d  = tc ? mod_q : cnt_q - CNT_ONE;             // RL8
        pend_d = 1'b0;
      end
    end

    // pulse width: half source clock, one, or 32
    if (func_q.mode == MODE_PULSE && out_q) begin
      unique case (func_q.pre)
        PRE_DIV1: pulse_end = src_rise;                    // RL4
        PRE_DIV2: pulse_end = irise;                       // RL4
        default:  pulse_end = irise;                       // RL4
      endcase
      if (pulse_end) out_d = 1'b0;
    end

    // modulus writes never touch the prescaler
    if (wr_lo) mod_d[7:0]  = req.dat[7:0];                 // RL12
    if (wr_hi) mod_d[15:8] = req.dat[7:0];
    if ((wr_lo || wr_hi) && st_q != ST_RUN && iclk_q) begin
      cnt_d = wr_lo ? {mod_q[15:8], req.dat[7:0]}
                    : {req.dat[7:0], mod_q[7:0]};          // RL11
    end

    if (wr_start && st_q == ST_ARMED) begin
      st_d  = ST_RUN;                                      // RL15
      cnt_d = mod_q;
      if (func_q.mode == MODE_SQUARE) out_d = 1'b1;        // RL1
    end

    if (wr_func) begin
      func_d = req.dat[FUNC_W-1:0];                        // RL13
      if (twp_is_stop(req.dat[MODE_W-1:0])) begin
        st_d   = ST_STOP;                                  // RL7 RL14
        pre_d  = PRE_ZERO;                                 // RL7
        iclk_d = 1'b1;                                     // RL7 RL14
        out_d  = 1'b0;                                     // RL14
      end else if (st_q == ST_STOP) begin
        st_d = ST_ARMED;
      end
    end
    if (twp_is_stop(func_q.mode)) out_d = 1'b0;            // RL14

    // sticky status, set wins over read clear
    if (rd_status) stat_d = '0;
    if (tc) stat_d[IRQ_TC] = 1'b1;
    if (tick && rd_count) stat_d[IRQ_RDBLK] = 1'b1;
    if (wr & (req.adr == ADDR_MASK)) mask_d = req.dat[IRQ_W-1:0];
  end

  // read mux and ack
  always_comb begin
    dat_d = '0;
    ack_d = acc;
    if (rd) begin
      unique case (req.adr)
        ADDR_FUNC:   dat_d[FUNC_W-1:0] = func_q;
        ADDR_MOD_LO: dat_d[7:0] = mod_q[7:0];
        ADDR_MOD_HI: dat_d[7:0] = mod_q[15:8];
        ADDR_COUNT:  dat_d[15:0] = buf_q;
        ADDR_STATUS: dat_d[IRQ_W-1:0] = stat_q;
        ADDR_MASK:   dat_d[IRQ_W-1:0] = mask_q;
        default:     dat_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q   <= ST_STOP;
      func_q <= '0;
      mod_q  <= '0;
      cnt_q  <= '0;
      buf_q  <= '0;
      pre_q  <= '0;
      iclk_q <= 1'b1;
      out_q  <= 1'b0;
      pend_q <= 1'b0;
      stat_q <= '0;
      mask_q <= '0;
      dat_q  <= '0;
      ack_q  <= 1'b0;
      irq_o  <= 1'b0;
      timer_out_o <= 1'b0;
    end else begin
      st_q   <= st_d;
      func_q <= func_d;
      mod_q  <= mod_d;
      cnt_q  <= cnt_d;
      buf_q  <= buf_d;
      pre_q  <= pre_d;
      iclk_q <= iclk_d;
      out_q  <= out_d;
      pend_q <= pend_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      dat_q  <= dat_d;
      ack_q  <= ack_d;
      irq_o  <= |(stat_d & mask_d);
      timer_out_o <= out_d ^ func_d.pol;
    end
  end

  always_comb begin
    ack_o       = ack_q;
    dat_o       = dat_q;
  end

endmodule : twp_timer

//--- dv/twp_timer_assertions.sv
/* checker for twp_timer: bus handshake, idle and start output.
   assumes it is bound to the twp_timer ports. */
`timescale 1ns/10ps
module twp_timer_chk
  import twp_pkg::*;
(
  // watched ports
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        timer_out_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic wr;
  logic stop_d, stop_q, pol_d, pol_q, sq_d, sq_q, mz_d, mz_q;
  // track writes at the edge the slave takes them
  assign wr = cyc_i && stb_i && !ack_o && we_i && sel_i[0];
  always_comb begin
    {stop_d, pol_d, sq_d, mz_d} = {stop_q, pol_q, sq_q, mz_q};
    if (wr && adr_i == ADDR_FUNC) begin
      stop_d = dat_i[2:0] inside {MODE_STOP0, MODE_STOP7};
      pol_d = dat_i[POL_BIT];
      sq_d = stop_q && dat_i[2:0] == MODE_SQUARE;
    end
    if (wr && adr_i == ADDR_START) sq_d = 1'b0;
    if (wr && adr_i == ADDR_MASK) mz_d = dat_i[1:0] == 2'h0;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) {stop_q, pol_q, sq_q, mz_q} <= 4'h9;
    else {stop_q, pol_q, sq_q, mz_q} <= {stop_d, pol_d, sq_d, mz_d};
  end
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
  property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data idle");
  property p_unmapped;
    ack_o && !we_i && adr_i > ADDR_MASK |-> dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_stop_idle;
    stop_q && $past(stop_q, 2) && $stable(pol_q) |-> timer_out_o == pol_q;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("out busy");
  property p_sq_start;
    wr && adr_i == ADDR_START && sq_q |-> ##[0:3] timer_out_o != pol_q;
  endproperty
  a_sq_start: assert property (p_sq_start) else $error("no start");
  property p_irq_off; mz_q && $past(mz_q) |-> !irq_o; endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked irq");
  c_start: cover property (wr && adr_i == ADDR_START && sq_q);
  c_count: cover property (ack_o && !we_i && adr_i == ADDR_COUNT);
  c_irq: cover property (irq_o);
endmodule : twp_timer_chk
bind twp_timer twp_timer_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .timer_out_o(timer_out_o), .irq_o(irq_o));

//--- dv/twp_host.sv
/* host model: wishbone master and the timer programming order.
   assumes one twp_timer slave on the same clock. */
`timescale 1ns/10ps
module twp_host
  import twp_pkg::*;
(
  // bus
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output twp_req_t         req_o,
  output logic             cyc_o
);
  initial begin
    req_o = '0;
    cyc_o = 1'b0;
  end
  task automatic xfer(input twp_req_t r, output logic [31:0] d);
    @(posedge clk_i);
    req_o <= r;
    cyc_o <= 1'b1;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    d = dat_i;
    cyc_o <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    xfer('{a, 1'b1, 4'hF, v}, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer('{a, 1'b0, 4'hF, 32'h0}, d);
  endtask : rd
  task automatic prog(input twp_func_t f, input logic [15:0] m);
    wr(ADDR_FUNC, 32'h0);
    wr(ADDR_FUNC, {26'h0, f});
    wr(ADDR_MOD_LO, {24'h0, m[7:0]});
    wr(ADDR_MOD_HI, {24'h0, m[15:8]});
    wr(ADDR_START, 32'h0);
  endtask : prog
endmodule : twp_host

//--- dv/twp_timer_tb.sv
/* bench for twp_timer: bus, square, pulse, stop and interrupt runs.
   assumes twp_host as master; source clock is clk_i divided by 8. */
`timescale 1ns/10ps
module twp_timer_tb
  import twp_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [2:0]  sc = 3'h0;
  logic        cyc, ack, tout, irq;
  logic [31:0] rdat;
  twp_req_t    req;
  int          n_errors = 0;
  int          comparisons = 0;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) sc <= sc + 3'h1;
  twp_host u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .req_o(req),
    .cyc_o(cyc));
  twp_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc),
    .we_i(req.we), .adr_i(req.adr), .sel_i(req.sel), .dat_i(req.dat),
    .dat_o(rdat), .ack_o(ack), .timer_source_clock_i(sc[2]),
    .timer_gate_input_i(1'b0), .timer_out_o(tout), .irq_o(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // source rising edges until the output changes
  task automatic span(output logic [31:0] n);
    logic v;
    v = tout;
    n = 0;
    while (tout === v) begin
      @(posedge clk_i);
      if (sc == 3'h3) n++;
    end
  endtask : span
  task automatic test_done;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic t_reset;
    logic [31:0] d;
    check({30'h0, irq, tout}, 32'h0);
    u_host.rd(8'h1C, d);
    check(d, 32'h0);
    u_host.wr(ADDR_FUNC, 32'h2D);
    u_host.rd(ADDR_FUNC, d);
    check(d, 32'h2D);
  endtask : t_reset
  task automatic t_square;
    logic [31:0] n;
    u_host.prog({1'b0, PRE_DIV2, MODE_SQUARE}, 16'h0003);
    repeat (3) @(posedge clk_i);
    check(tout, 1'b1);
    span(n);
    span(n);
    check(n, 32'h8);
    fork
      span(n);
      begin
        u_host.wr(ADDR_MOD_LO, 32'h5);
        u_host.wr(ADDR_MOD_HI, 32'h0);
      end
    join
    check(n, 32'h8);
    span(n);
    check(n, 32'hC);
  endtask : t_square
  task automatic t_pulse(input logic [1:0] pre, input logic [31:0] w, p);
    logic [31:0] n;
    u_host.prog({1'b0, pre, MODE_PULSE}, 16'h0002);
    span(n);
    span(n);
    check(n, w);
    span(n);
    check(n + w, p);
  endtask : t_pulse
  task automatic t_irq_stop;
    logic [31:0] a, b;
    u_host.prog({1'b0, PRE_DIV1, MODE_SQUARE}, 16'h0004);
    // drop status left over from earlier runs
    u_host.rd(ADDR_STATUS, a);
    u_host.wr(ADDR_MASK, 32'h1);
    wait (irq === 1'b1);
    u_host.rd(ADDR_STATUS, a);
    check(a[IRQ_TC], 1'b1);
    repeat (2) @(posedge clk_i);
    check(irq, 1'b0);
    u_host.wr(ADDR_MASK, 32'h0);
    span(a);
    span(a);
    check(irq, 1'b0);
    u_host.wr(ADDR_FUNC, 32'h0);
    u_host.rd(ADDR_COUNT, a);
    repeat (40) @(posedge clk_i);
    u_host.rd(ADDR_COUNT, b);
    check(b, a);
    check(tout, 1'b0);
  endtask : t_irq_stop
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_square();
    t_pulse(PRE_DIV2, 32'h1, 32'h6);
    t_pulse(PRE_DIV64, 32'h20, 32'hC0);
    t_irq_stop();
    test_done();
  end
  initial begin
    #400us;
    n_errors++;
    test_done();
  end
endmodule : twp_timer_tb
